/* logic/ccgt_pkg.sv */
package ccgt_pkg;
	localparam logic [7:0] CCGT_CTRL_OFS = 8'h00;
	localparam logic [7:0] CCGT_LINE_OFS = 8'h04;
	localparam logic [7:0] CCGT_DATA_OFS = 8'h08;
	localparam logic [7:0] CCGT_STAT_OFS = 8'h0C;
	localparam logic [7:0] CCGT_INT_STAT_OFS = 8'h10;
	localparam logic [7:0] CCGT_INT_MASK_OFS = 8'h14;
	localparam int CCGT_CTRL_TYPE_POS = 0;
	localparam int CCGT_CTRL_SIZE_POS = 2;
	localparam int CCGT_CTRL_START_POS = 4;
	localparam int CCGT_STAT_BUSY_POS = 0;
	localparam int CCGT_STAT_ATTACH_POS = 1;
	localparam int CCGT_STAT_PROCEED_POS = 2;
	localparam int CCGT_STAT_TAKEN_POS = 3;
	localparam int CCGT_STAT_PENDING_POS = 4;
	localparam int CCGT_STAT_PARITY_POS = 5;
	localparam int CCGT_STAT_GROUP_END_POS = 6;
	localparam int CCGT_STAT_STOP_POS = 7;
	localparam int CCGT_STAT_COUNT_POS = 8;
	localparam int CCGT_STAT_STATE_POS = 10;
	localparam int CCGT_EV_DONE = 0;
	localparam int CCGT_EV_PARITY = 1;
	localparam int CCGT_EV_STOP = 2;
	localparam int CCGT_EV_COUNT = 3;
	localparam logic [1:0] CCGT_RESP_OKAY = 2'h0;
	localparam logic [1:0] CCGT_RESP_SLVERR = 2'h2;
	localparam logic [2:0] CCGT_INT_MASK_RST = 3'h0;

	typedef enum logic [1:0] {
		CCGT_SVC_READ,
		CCGT_SVC_WRITE,
		CCGT_SVC_SENSE,
		CCGT_SVC_STATUS
	} ccgt_svc_t;

	typedef enum logic [2:0] {
		CCGT_IDLE,
		CCGT_REQUEST,
		CCGT_ADDRESS,
		CCGT_TRANSFER,
		CCGT_STATUS,
		CCGT_RELEASE
	} ccgt_state_t;

	typedef struct packed {
		logic request_in;
		logic operation_in;
		logic address_in;
		logic service_in;
		logic status_in;
		logic [8:0] bus_in;
	} ccgt_chan_in_t;

	typedef struct packed {
		logic select_out;
		logic command_out;
		logic service_out;
		logic [8:0] bus_out;
	} ccgt_chan_out_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ccgt_axi_t;

	typedef struct packed {
		ccgt_axi_t axi;
		ccgt_chan_in_t chan;
		ccgt_state_t state;
		ccgt_svc_t svc_type;
		logic [7:0] line_addr;
		logic [7:0] stor_addr;
		logic [31:0] data;
		logic [1:0] group_size_count;
		logic [1:0] moved_char_count;
		logic wait_low;
		logic service_attach;
		logic proceed_flag;
		logic status_taken;
		logic transfer_pending;
		logic write_parity_fault;
		logic data_stop;
		logic stop;
		logic [2:0] int_stat;
		logic [2:0] int_mask;
		logic irq;
	} ccgt_state_s_t;
endpackage

/* logic/ccgt_top.sv */
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module ccgt_top
	import ccgt_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire ccgt_chan_out_t chan_out,
	output ccgt_chan_in_t chan_in,
	output logic [7:0] stor_addr,
	output logic irq
);
	ccgt_state_s_t s;
	ccgt_state_s_t next_s;

	// Odd parity bit: the nine lines together carry an odd count of ones.
	function automatic logic odd_par(input logic [7:0] b);
		odd_par = ~(^b);
	endfunction

	// Byte idx of a data word; idx 0 is register A and idx 3 is register D.
	function automatic logic [7:0] pick_byte(input logic [31:0] d, input logic [1:0] idx);
		pick_byte = d[{idx, 3'h0} +: 8];
	endfunction

	function automatic logic [31:0] put_byte(input logic [31:0] d, input logic [1:0] idx,
		input logic [7:0] b);
		logic [31:0] r;
		r = d;
		r[{idx, 3'h0} +: 8] = b;
		put_byte = r;
	endfunction

	// Control register image: service type and group size as last written, except that a sense start forces the size to zero.
	function automatic logic [31:0] ctrl_word(input ccgt_state_s_t st);
		logic [31:0] r;
		r = 32'h0000_0000;
		r[CCGT_CTRL_TYPE_POS +: 2] = st.svc_type;
		r[CCGT_CTRL_SIZE_POS +: 2] = st.group_size_count;
		ctrl_word = r;
	endfunction

	// Status register image of the interface flags and counters.
	function automatic logic [31:0] status_word(input ccgt_state_s_t st);
		logic [31:0] r;
		r = 32'h0000_0000;
		r[CCGT_STAT_BUSY_POS] = st.state != CCGT_IDLE;
		r[CCGT_STAT_ATTACH_POS] = st.service_attach;
		r[CCGT_STAT_PROCEED_POS] = st.proceed_flag;
		r[CCGT_STAT_TAKEN_POS] = st.status_taken;
		r[CCGT_STAT_PENDING_POS] = st.transfer_pending;
		r[CCGT_STAT_PARITY_POS] = st.write_parity_fault;
		r[CCGT_STAT_GROUP_END_POS] = st.data_stop;
		r[CCGT_STAT_STOP_POS] = st.stop;
		r[CCGT_STAT_COUNT_POS +: 2] = st.moved_char_count;
		r[CCGT_STAT_STATE_POS +: 3] = st.state;
		status_word = r;
	endfunction

	// Read data image of a register; unmapped offsets read as zero.
	function automatic logic [31:0] read_mux(input ccgt_state_s_t st, input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			CCGT_CTRL_OFS: r = ctrl_word(st);
			CCGT_LINE_OFS: r[7:0] = st.line_addr;
			CCGT_DATA_OFS: r = st.data;
			CCGT_STAT_OFS: r = status_word(st);
			CCGT_INT_STAT_OFS: r[CCGT_EV_COUNT-1:0] = st.int_stat;
			CCGT_INT_MASK_OFS: r[CCGT_EV_COUNT-1:0] = st.int_mask;
			default: r = 32'h0000_0000;
		endcase
		read_mux = r;
	endfunction

	// Only mapped offsets answer OKAY; the rest get SLVERR and change nothing.
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == CCGT_CTRL_OFS) || (a == CCGT_LINE_OFS) || (a == CCGT_DATA_OFS) ||
			(a == CCGT_STAT_OFS) || (a == CCGT_INT_STAT_OFS) || (a == CCGT_INT_MASK_OFS);
	endfunction

	// Byte lanes of a data write, each lane under its own strobe.
	function automatic logic [31:0] merge_lanes(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		merge_lanes = r;
	endfunction

	// Nine-line bus image of a byte with its odd parity bit on top.
	function automatic logic [8:0] bus_word(input logic [7:0] b);
		bus_word = {odd_par(b), b};
	endfunction

	// True once the channel has dropped both of its answering tags.
	function automatic logic tags_idle(input ccgt_chan_out_t c);
		tags_idle = !c.service_out && !c.command_out;
	endfunction

	// An even count of ones over the nine Bus Out lines is a parity fault.
	function automatic logic parity_bad(input logic [8:0] w);
		parity_bad = ~(^w);
	endfunction

	always_comb begin
		logic start;
		logic [2:0] ev;
		logic [7:0] b;
		logic last;
		start = 1'b0;
		ev = 3'h0;
		b = 8'h00;
		last = s.moved_char_count == s.group_size_count;
		next_s = s;
		next_s.axi.awready = 1'b0;
		next_s.axi.wready = 1'b0;
		next_s.axi.arready = 1'b0;

		// Write channel: address and data are taken together, one write at a time.
		if (s.axi.bvalid && s_axi_bready) begin
			next_s.axi.bvalid = 1'b0;
		end
		if (!s.axi.bvalid && s_axi_awvalid && s_axi_wvalid) begin
			next_s.axi.awready = 1'b1;
			next_s.axi.wready = 1'b1;
			next_s.axi.bvalid = 1'b1;
			next_s.axi.bresp = mapped(s_axi_awaddr) ? CCGT_RESP_OKAY : CCGT_RESP_SLVERR;
			case (s_axi_awaddr)
				CCGT_CTRL_OFS: begin
					if (s_axi_wstrb[0] && s.state == CCGT_IDLE) begin
						next_s.svc_type = ccgt_svc_t'(s_axi_wdata[CCGT_CTRL_TYPE_POS +: 2]);
						next_s.group_size_count = s_axi_wdata[CCGT_CTRL_SIZE_POS +: 2];
						start = s_axi_wdata[CCGT_CTRL_START_POS];
					end
				end
				CCGT_LINE_OFS: begin
					if (s_axi_wstrb[0] && s.state == CCGT_IDLE) begin
						next_s.line_addr = s_axi_wdata[7:0];
					end
				end
				CCGT_DATA_OFS: begin
					// The data registers belong to the channel side while a cycle runs.
					if (s.state == CCGT_IDLE) begin
						next_s.data = merge_lanes(s.data, s_axi_wdata, s_axi_wstrb);
					end
				end
				CCGT_INT_MASK_OFS: begin
					if (s_axi_wstrb[0]) begin
						next_s.int_mask = s_axi_wdata[CCGT_EV_COUNT-1:0];
					end
				end
				default: begin
				end
			endcase
		end

		// Read channel; reading the interrupt status clears it.
		if (s.axi.rvalid && s_axi_rready) begin
			next_s.axi.rvalid = 1'b0;
		end
		if (!s.axi.rvalid && s_axi_arvalid) begin
			next_s.axi.arready = 1'b1;
			next_s.axi.rvalid = 1'b1;
			next_s.axi.rdata = read_mux(s, s_axi_araddr);
			next_s.axi.rresp = mapped(s_axi_araddr) ? CCGT_RESP_OKAY : CCGT_RESP_SLVERR;
			if (s_axi_araddr == CCGT_INT_STAT_OFS) begin
				next_s.int_stat = 3'h0;
			end
		end

		// Every channel tag is a level that the channel answers, so each step waits
		// for the matching channel tag before it moves on.
		case (s.state)
			CCGT_IDLE: begin
				if (start) begin
					next_s.state = CCGT_REQUEST;
					next_s.chan.request_in = 1'b1;
					// A new cycle clears the flags of the last one, so a stale fault
					// cannot leak into its status.
					next_s.proceed_flag = 1'b0;
					next_s.status_taken = 1'b0;
					next_s.write_parity_fault = 1'b0;
					next_s.data_stop = 1'b0;
					next_s.stop = 1'b0;
					next_s.moved_char_count = 2'h0;
					next_s.wait_low = 1'b0;
					// A sense cycle moves the single sense byte held in register C.
					if (ccgt_svc_t'(s_axi_wdata[CCGT_CTRL_TYPE_POS +: 2]) == CCGT_SVC_SENSE) begin
						next_s.group_size_count = 2'h0;
					end
				end
			end
			CCGT_REQUEST: begin
				if (chan_out.select_out) begin
					next_s.chan.request_in = 1'b0;
					next_s.chan.operation_in = 1'b1;
					next_s.service_attach = 1'b1;
					next_s.chan.address_in = 1'b1;
					next_s.chan.bus_in = bus_word(s.line_addr);
					next_s.stor_addr = s.line_addr;
					next_s.state = CCGT_ADDRESS;
				end
			end
			CCGT_ADDRESS: begin
				if (chan_out.command_out) begin
					next_s.chan.address_in = 1'b0;
					next_s.proceed_flag = 1'b1;
					if (s.svc_type == CCGT_SVC_STATUS) begin
						b = pick_byte(s.data, 2'h3);
						next_s.chan.status_in = 1'b1;
						next_s.chan.bus_in = bus_word(b);
						// The status byte counts as pending until taken or stacked.
						next_s.transfer_pending = 1'b1;
						next_s.state = CCGT_STATUS;
					end else begin
						if (s.svc_type == CCGT_SVC_SENSE) begin
							b = pick_byte(s.data, 2'h2);
						end else if (s.svc_type == CCGT_SVC_READ) begin
							b = pick_byte(s.data, 2'h0);
						end
						next_s.chan.service_in = 1'b1;
						next_s.chan.bus_in = (s.svc_type == CCGT_SVC_WRITE) ? 9'h000 :
							{odd_par(b), b};
						next_s.transfer_pending = 1'b1;
						next_s.state = CCGT_TRANSFER;
					end
				end
			end
			CCGT_TRANSFER: begin
				// wait_low holds the next byte back until the channel has dropped its
				// answering tag, which keeps the handshake fully interlocked.
				if (!s.wait_low) begin
					if (chan_out.service_out) begin
						// Bus Out is sampled only while the pending condition invites data.
						if (s.svc_type == CCGT_SVC_WRITE) begin
							next_s.data = put_byte(s.data, s.moved_char_count,
								chan_out.bus_out[7:0]);
							if (parity_bad(chan_out.bus_out)) begin
								next_s.write_parity_fault = 1'b1;
								ev[CCGT_EV_PARITY] = 1'b1;
							end
						end
						next_s.moved_char_count = s.moved_char_count + 2'h1;
						next_s.chan.service_in = 1'b0;
						next_s.transfer_pending = 1'b0;
						next_s.wait_low = 1'b1;
						if (last) begin
							next_s.data_stop = 1'b1;
						end
					end else if (chan_out.command_out) begin
						next_s.stop = 1'b1;
						ev[CCGT_EV_STOP] = 1'b1;
						next_s.chan.service_in = 1'b0;
						next_s.transfer_pending = 1'b0;
						next_s.state = CCGT_RELEASE;
					end
				end else if (tags_idle(chan_out)) begin
					next_s.wait_low = 1'b0;
					if (s.data_stop) begin
						next_s.state = CCGT_RELEASE;
					end else begin
						b = pick_byte(s.data, s.moved_char_count);
						next_s.chan.service_in = 1'b1;
						next_s.chan.bus_in = (s.svc_type == CCGT_SVC_WRITE) ? 9'h000 :
							{odd_par(b), b};
						next_s.transfer_pending = 1'b1;
					end
				end
			end
			CCGT_STATUS: begin
				if (chan_out.service_out) begin
					next_s.status_taken = 1'b1;
					next_s.chan.status_in = 1'b0;
					next_s.transfer_pending = 1'b0;
					next_s.state = CCGT_RELEASE;
				end else if (chan_out.command_out) begin
					next_s.stop = 1'b1;
					ev[CCGT_EV_STOP] = 1'b1;
					next_s.chan.status_in = 1'b0;
					next_s.transfer_pending = 1'b0;
					next_s.state = CCGT_RELEASE;
				end
			end
			CCGT_RELEASE: begin
				// Stay attached until the channel has dropped its answering tag.
				if (tags_idle(chan_out)) begin
					next_s.chan.operation_in = 1'b0;
					next_s.service_attach = 1'b0;
					next_s.chan.bus_in = 9'h000;
					next_s.state = CCGT_IDLE;
					ev[CCGT_EV_DONE] = 1'b1;
				end
			end
			default: begin
				next_s.state = CCGT_IDLE;
			end
		endcase

		// Events are applied after the read clear, so a new event is never lost.
		next_s.int_stat = next_s.int_stat | ev;
		next_s.irq = |(next_s.int_stat & next_s.int_mask);
	end

	// Reset clears every flag and output; the enum fields and the mask get named values.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.state <= CCGT_IDLE;
			s.svc_type <= CCGT_SVC_READ;
			s.int_mask <= CCGT_INT_MASK_RST;
		end else begin
			s <= next_s;
		end
	end

	// Every output is read straight from the registered state.
	assign s_axi_awready = s.axi.awready;
	assign s_axi_wready = s.axi.wready;
	assign s_axi_bvalid = s.axi.bvalid;
	assign s_axi_bresp = s.axi.bresp;
	assign s_axi_arready = s.axi.arready;
	assign s_axi_rvalid = s.axi.rvalid;
	assign s_axi_rdata = s.axi.rdata;
	assign s_axi_rresp = s.axi.rresp;
	assign chan_in = s.chan;
	assign stor_addr = s.stor_addr;
	assign irq = s.irq;
endmodule
`default_nettype wire

/* tb/ccgt_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module ccgt_asserts
	import ccgt_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire ccgt_chan_out_t chan_out,
	input wire ccgt_chan_in_t chan_in,
	input wire logic [7:0] stor_addr,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence attach_s;
		chan_in.request_in && chan_out.select_out;
	endsequence
	sequence bound_s;
		chan_in.operation_in && chan_in.address_in && !chan_in.request_in;
	endsequence
	chk_req_held: assert property (
		chan_in.request_in && !chan_out.select_out |=> chan_in.request_in)
		else $error("request dropped");
	chk_attach_tags: assert property (attach_s |=> bound_s)
		else $error("attach tags wrong");
	chk_addr_bus: assert property (
		chan_in.address_in |-> chan_in.bus_in[7:0] == stor_addr && ^chan_in.bus_in)
		else $error("address byte wrong");
	chk_addr_ack: assert property (
		chan_in.address_in && chan_out.command_out |=> !chan_in.address_in && chan_in.operation_in)
		else $error("address ack ignored");
	chk_byte_ack: assert property (
		chan_in.service_in && chan_out.service_out |=> !chan_in.service_in)
		else $error("byte ack ignored");
	chk_svc_gap: assert property (
		$rose(chan_in.service_in) |-> !$past(chan_out.service_out))
		else $error("byte offered too early");
	chk_tags_attached: assert property (
		chan_in.service_in || chan_in.status_in |-> chan_in.operation_in && !chan_in.request_in)
		else $error("tag without attach");
	chk_status_par: assert property (chan_in.status_in |-> ^chan_in.bus_in)
		else $error("status parity");
	chk_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped");
endmodule
bind ccgt_top ccgt_asserts ccgt_asserts_i(.aclk(aclk), .aresetn(aresetn), .chan_out(chan_out),
	.chan_in(chan_in), .stor_addr(stor_addr), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready));
`default_nettype wire

/* tb/ccgt_chan_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ccgt_chan_model
	import ccgt_pkg::*;
(
	input wire logic aclk,
	input wire ccgt_chan_in_t chan_in,
	input wire logic [7:0] wr_byte,
	input wire logic bad_par,
	input wire logic stop_req,
	input wire logic stack_req,
	input wire logic [3:0] dly,
	output ccgt_chan_out_t chan_out
);
	logic [7:0] k;
	initial begin
		chan_out = '0;
		forever begin
			@(posedge aclk);
			if (chan_in.request_in) begin
				repeat (dly) @(posedge aclk);
				chan_out.select_out <= 1'b1;
				do @(posedge aclk); while (!chan_in.address_in);
				chan_out.select_out <= 1'b0;
				chan_out.command_out <= 1'b1;
				@(posedge aclk);
				chan_out.command_out <= 1'b0;
				k = 8'h00;
				while (chan_in.operation_in) begin
					@(posedge aclk);
					if (chan_in.service_in || chan_in.status_in) begin
						repeat (dly) @(posedge aclk);
						chan_out.bus_out <= {~^(wr_byte + k) ^ bad_par, wr_byte + k};
						if (chan_in.status_in ? stack_req : stop_req)
							chan_out.command_out <= 1'b1;
						else
							chan_out.service_out <= 1'b1;
						do @(posedge aclk); while (chan_in.service_in || chan_in.status_in);
						chan_out.service_out <= 1'b0;
						chan_out.command_out <= 1'b0;
						chan_out.bus_out <= ~chan_out.bus_out;
						k = k + 8'h01;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top
	import ccgt_pkg::*;
;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, stor_addr, wr_byte = 8'h00, line = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv, data, seed = 32'd97;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, irq;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp, ty = 2'h0;
	logic bad_par = 1'b0, stop_req = 1'b0, stack_req = 1'b0;
	logic [2:0] msk = 3'h0;
	logic [3:0] dly = 4'h0;
	logic [7:0] got[$], exp_q[$];
	ccgt_chan_out_t chan_out;
	ccgt_chan_in_t chan_in;
	int n_fail = 0, n_tests = 0, cyc = 0;
	ccgt_top ccgt_top_i(.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chan_out, .chan_in,
		.stor_addr, .irq);
	ccgt_chan_model ccgt_chan_model_i(.aclk, .chan_in, .wr_byte, .bad_par, .stop_req,
		.stack_req, .dly, .chan_out);
	always #4 aclk = ~aclk;
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_awready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rv = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// One full service cycle of type t, moving sz+1 bytes for a read or write without a stop,
	// none for a write with a stop and one byte otherwise, checked against the bench model.
	task automatic run(input logic [1:0] t, input logic [1:0] sz);
		int n;
		logic [31:0] e;
		data = xs();
		line = 8'(xs());
		wr_byte <= 8'(xs());
		dly <= 4'(xs() & 32'h3);
		ty = t;
		got = {};
		exp_q = {};
		wr(CCGT_DATA_OFS, data);
		wr(CCGT_LINE_OFS, {24'h0, line});
		wr(CCGT_CTRL_OFS, {27'h0, 1'b1, sz, t});
		do rd(CCGT_STAT_OFS); while (rv[CCGT_STAT_BUSY_POS] !== 1'b0);
		`CHK(stor_addr, line)
		n = (t > 2'd1 || stop_req) ? 1 : sz + 1;
		for (int i = 0; i < n; i++)
			exp_q.push_back(t == 2'd2 ? data[23:16] : t == 2'd3 ? data[31:24] : data[8*i +: 8]);
		if (t == 2'd1) begin
			e = data;
			for (int i = 0; i <= sz && !stop_req; i++)
				e[8*i +: 8] = wr_byte + 8'(i);
			rd(CCGT_DATA_OFS);
			`CHK(rv, e)
		end else begin
			`CHK(got.size(), n)
			foreach (exp_q[i]) `CHK(got[i], exp_q[i])
		end
		rd(CCGT_STAT_OFS);
		`CHK(rv[CCGT_STAT_STOP_POS], stop_req | stack_req)
		`CHK(rv[CCGT_STAT_PARITY_POS], bad_par)
		`CHK(rv[CCGT_STAT_TAKEN_POS], t == 2'd3 && !stack_req)
		`CHK(rv[CCGT_STAT_PENDING_POS], 1'b0)
		`CHK(irq, msk != 3'h0)
		rd(CCGT_INT_STAT_OFS);
		`CHK(rv[2:0], {stop_req | stack_req, bad_par, 1'b1})
		repeat (2) @(posedge aclk);
		`CHK(irq, 1'b0)
	endtask
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			end_sim();
		end
		if (chan_in.address_in && chan_out.command_out)
			`CHK(chan_in.bus_in[7:0], line)
		if ((chan_in.service_in || chan_in.status_in) && ty != 2'd1
			&& (chan_out.service_out || chan_out.command_out)) begin
			got.push_back(chan_in.bus_in[7:0]);
			`CHK(^chan_in.bus_in, 1'b1)
		end
	end
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(CCGT_INT_MASK_OFS);
		`CHK(rv, 32'h0)
		rd(8'h18);
		`CHK(rsp, CCGT_RESP_SLVERR)
		wr(8'h18, 32'hFFFFFFFF);
		`CHK(rsp, CCGT_RESP_SLVERR)
		run(2'd0, 2'd3);
		msk = 3'h7;
		wr(CCGT_INT_MASK_OFS, 32'h7);
		for (int s = 0; s < 4; s++)
			run(2'(s), 2'(s));
		stop_req <= 1'b1;
		run(2'd0, 2'd1);
		run(2'd1, 2'd2);
		stop_req <= 1'b0;
		bad_par <= 1'b1;
		run(2'd1, 2'd3);
		bad_par <= 1'b0;
		stack_req <= 1'b1;
		run(2'd3, 2'd0);
		stack_req <= 1'b0;
		end_sim();
	end
endmodule
`default_nettype wire
